// *** core/frame_if.sv ***
// Frame handshake between serial shifter and status core
`timescale 1ns/1ns
interface frame_if;
  import stat_pkg::*;
  logic [WORD_W-1:0] tx_word;
  logic start;
  logic done;
  logic good;
  logic [WORD_W-1:0] rx_word;
  modport shifter (input tx_word, output start, done, good, rx_word);
  modport core (output tx_word, input start, done, good, rx_word);
endinterface

// *** core/spi_status_readback_map.sv ***
// Status readback word map returned on the serial data output
`timescale 1ns/1ns
module spi_status_readback_map
  import stat_pkg::*;
#(
  parameter logic [2:0] DEVICE_TYPE = 3'h0,  // Arbitrary value
  parameter logic [1:0] DEVICE_FAMILY = 2'h0,  // Arbitrary value
  parameter logic [2:0] DESIGN_REV = 3'h1  // Arbitrary value
)(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CSB,
  input wire logic SCLK,
  input wire logic SI,
  output logic SO_DATA,
  output logic SO_OE_N,
  input wire logic LIMP_PIN,
  input wire logic [NIN-1:0] DIRECT_IN,
  input wire logic [NCH-1:0] OUT_CMP,
  input wire logic FAIL_MODE,
  input wire logic [NIN-1:0] INPUT_ON,
  input wire logic [3*NCH-1:0] CH_OC_CODE,
  input wire logic [NCH-1:0] CH_OTW,
  input wire logic [NCH-1:0] CH_OTS,
  input wire logic [NCH-1:0] CH_OLON,
  input wire logic [NCH-1:0] CH_OLOFF,
  input wire logic UNDERVOLT,
  input wire logic OVERVOLT,
  input wire logic CP_FAULT,
  input wire logic CLOCK_FAIL,
  input wire logic TEST_MODE
);
  frame_if fr ();

  logic [NPIN_SYNC-1:0] pins_s;
  logic csb_s;
  logic sclk_s;
  logic si_s;
  logic limp_s;
  logic [NIN-1:0] din_s;
  logic [NCH-1:0] cmp_s;
  logic [3:0] read_addr_r;
  logic [3:0] snap_addr_r;
  logic [WORD_W-1:0] snap_r;
  logic [2:0] oc_r [NCH];
  logic [NCH-1:0] otw_r;
  logic [NCH-1:0] ots_r;
  logic [NCH-1:0] olon_r;
  logic [NCH-1:0] oloff_r;
  logic [NCH-1:0] oc_any;
  logic [NCH-1:0] qsf;
  logic uv_r;
  logic ov_r;
  logic cp_r;
  logic pwm_clock_fail_flag_r;
  logic tm_r;
  logic rcf_r;
  logic serial_fail_flag_r;
  logic [DATA_W-1:0] word_a [16];

  sync_bank #(.W(NPIN_SYNC)) u_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .d({CSB, SCLK, SI, LIMP_PIN, DIRECT_IN, OUT_CMP}),
    .q(pins_s)
  );
  assign {csb_s, sclk_s, si_s, limp_s, din_s, cmp_s} = pins_s;

  word_shifter u_shift (
    .clk(CLK_SYS),
    .nrst(NRST),
    .csb_s(csb_s),
    .sclk_s(sclk_s),
    .si_s(si_s),
    .so_data(SO_DATA),
    .so_oe_n(SO_OE_N),
    .fr(fr)
  );

  // Read-clear acts only in a complete frame, on shipped bits; a quick-word read also clears uv_r, ov_r, tm_r on its bits 2 to 4
  wire rd_ok = fr.done & fr.good;
  wire bad_frame = fr.done & ~fr.good;
  wire clr_quick = rd_ok & (snap_addr_r == ADDR_QUICK);
  wire clr_dev = rd_ok & ((snap_addr_r == ADDR_QUICK) | (snap_addr_r == ADDR_DEVICE));
  wire clr_serial_fail_flag = rd_ok & (snap_addr_r == ADDR_DEVICE);

  wire open_load_summary_flag = (|olon_r) | (|oloff_r);
  wire overload_summary_flag = (|oc_any) | (|ots_r);
  wire device_summary_flag = uv_r | ov_r | cp_r | rcf_r | pwm_clock_fail_flag_r | tm_r;
  wire [3:0] summary = {FAIL_MODE, device_summary_flag, overload_summary_flag, open_load_summary_flag};
  wire toggle = |INPUT_ON;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      read_addr_r <= READ_ADDR_RST;
      snap_addr_r <= ADDR_UNUSED0;
      snap_r <= 16'h0000;
    end
    else
    begin
      if (fr.start)
      begin
        snap_addr_r <= read_addr_r;
        snap_r <= fr.tx_word;
      end
      if (rd_ok)
        read_addr_r <= fr.rx_word[WORD_W-1:WORD_W-4];
    end
  end

  // Per-channel sticky faults; a new event wins over a read-clear
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      wire [2:0] oc_in = CH_OC_CODE[3*i +: 3];
      wire clr = rd_ok & (snap_addr_r == (ADDR_CH1 + 4'(i)));
      always_ff @(posedge CLK_SYS or negedge NRST)
      begin
        if (!NRST)
        begin
          oc_r[i] <= OC_NONE;
          otw_r[i] <= 1'b0;
          ots_r[i] <= 1'b0;
          olon_r[i] <= 1'b0;
          oloff_r[i] <= 1'b0;
        end
        else
        begin
          if (oc_in != OC_NONE)
            oc_r[i] <= oc_in;
          else if (clr && snap_r[OC_LSB +: 3] == oc_r[i])
            oc_r[i] <= OC_NONE;
          otw_r[i] <= CH_OTW[i] | (otw_r[i] & ~(clr & snap_r[BIT_OTW]));
          ots_r[i] <= CH_OTS[i] | (ots_r[i] & ~(clr & snap_r[BIT_OTS]));
          olon_r[i] <= CH_OLON[i] | (olon_r[i] & ~(clr & snap_r[BIT_OLON]));
          oloff_r[i] <= CH_OLOFF[i] | (oloff_r[i] & ~(clr & snap_r[BIT_OLOFF]));
        end
      end
      assign oc_any[i] = (oc_r[i] != OC_NONE);
      assign qsf[i] = oc_any[i] | otw_r[i] | ots_r[i] | olon_r[i] | oloff_r[i];
      assign word_a[ADDR_CH1 + 4'(i)] = {summary, 1'b0, ots_r[i], otw_r[i], oc_r[i],
        olon_r[i], oloff_r[i]};
    end
  endgenerate

  // Device-level sticky flags
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      uv_r <= 1'b0;
      ov_r <= 1'b0;
      cp_r <= 1'b0;
      pwm_clock_fail_flag_r <= 1'b0;
      tm_r <= 1'b0;
      rcf_r <= RCF_RST;
      serial_fail_flag_r <= 1'b0;
    end
    else
    begin
      uv_r <= UNDERVOLT | (uv_r & ~(clr_dev & snap_r[BIT_UVF]));
      ov_r <= OVERVOLT | (ov_r & ~(clr_dev & snap_r[BIT_OVF]));
      tm_r <= TEST_MODE | (tm_r & ~(clr_dev & snap_r[BIT_TMF]));
      cp_r <= CP_FAULT | (cp_r & ~(clr_quick & snap_r[BIT_CPF]));
      pwm_clock_fail_flag_r <= CLOCK_FAIL | (pwm_clock_fail_flag_r & ~(clr_quick & snap_r[BIT_PWM_CLOCK_FAIL_FLAG]));
      rcf_r <= rcf_r & ~(clr_quick & snap_r[BIT_RCF]);
      serial_fail_flag_r <= bad_frame | (serial_fail_flag_r & ~(clr_serial_fail_flag & snap_r[BIT_SERIAL_FAIL_FLAG]));
    end
  end

  assign word_a[ADDR_UNUSED0] = UNUSED_FILL;
  assign word_a[ADDR_QUICK] = {summary, cp_r, rcf_r, pwm_clock_fail_flag_r, qsf};
  assign word_a[ADDR_DEVICE] = {summary, 3'h0, tm_r, ov_r, uv_r, serial_fail_flag_r, limp_s};
  assign word_a[ADDR_PIN_OUT] = {FAIL_MODE, 1'b0, toggle, din_s, cmp_s};
  assign word_a[ADDR_IDENT] = {FAIL_MODE, uv_r, 2'h0, DESIGN_REV, DEVICE_FAMILY,
    DEVICE_TYPE};
  generate
    for (genvar a = 10; a < 16; a++)
    begin : g_unused
      assign word_a[a] = UNUSED_FILL;
    end
  endgenerate

  assign fr.tx_word = {read_addr_r, word_a[read_addr_r]};

  // Checks
  logic alive_r;
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      alive_r <= 1'b0;
    else
      alive_r <= 1'b1;
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  addr_nibble_out_a: assert property (fr.start |-> fr.tx_word[WORD_W-1:WORD_W-4] == read_addr_r ##1 SO_DATA == $past(read_addr_r[3]))
    else $error("SO does not open with the address MSB");
  reset_flags_a: assert property (!alive_r |-> rcf_r && device_summary_flag && !overload_summary_flag && !open_load_summary_flag && !serial_fail_flag_r)
    else $error("Wrong flag values right after reset");
  chan_summary_a: assert property (CH_OTW[3] |=> word_a[ADDR_QUICK][3])
    else $error("Quick summary bit missed a channel warning");
  open_load_sum_a: assert property (CH_OLOFF[2] |=> word_a[ADDR_CH1][BIT_OPEN_LOAD] && word_a[ADDR_DEVICE][BIT_OPEN_LOAD])
    else $error("Open-load summary not raised");
  overload_sum_a: assert property (CH_OTS[4] |=> word_a[ADDR_QUICK][BIT_OVERLOAD])
    else $error("Overload summary not raised");
  dev_summary_a: assert property (UNDERVOLT |=> word_a[ADDR_QUICK][BIT_DEV_SUM] && word_a[ADDR_IDENT][BIT_ID_UV])
    else $error("Undervoltage not reflected in summaries");
  oc_code_a: assert property (CH_OC_CODE[2:0] != 3'h0 |=> word_a[ADDR_CH1][OC_LSB +: 3] == $past(CH_OC_CODE[2:0]))
    else $error("Overcurrent code not latched");
  open_off_hold_a: assert property (oloff_r[1] && !(rd_ok && snap_addr_r == 4'h3) |=> oloff_r[1])
    else $error("Open-load-off bit lost without a read");
  serial_fail_a: assert property (bad_frame |=> word_a[ADDR_DEVICE][BIT_SERIAL_FAIL_FLAG])
    else $error("Serial fail flag not set by a broken frame");
  limp_live_a: assert property (LIMP_PIN ##1 LIMP_PIN ##1 LIMP_PIN |-> word_a[ADDR_DEVICE][BIT_LIMP])
    else $error("Limp level not shown live");
  pin_toggle_a: assert property (|INPUT_ON |-> word_a[ADDR_PIN_OUT][BIT_TOGGLE] ##1 1'b1)
    else $error("Input-on OR not shown");

  quick_read_c: cover property (rd_ok && snap_addr_r == ADDR_QUICK && snap_r[BIT_RCF]);
  bad_frame_c: cover property (bad_frame);
  chan_clear_c: cover property (rd_ok && snap_addr_r == ADDR_CH1 ##1 !qsf[0]);
endmodule

// *** core/stat_pkg.sv ***
// Constants for the serial status readback map
package stat_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 12;
  localparam int NCH = 5;
  localparam int NIN = 4;
  localparam int NPIN_SYNC = 13;
  // Word addresses
  localparam logic [3:0] ADDR_UNUSED0 = 4'h0;
  localparam logic [3:0] ADDR_QUICK = 4'h1;
  localparam logic [3:0] ADDR_CH1 = 4'h2;
  localparam logic [3:0] ADDR_DEVICE = 4'h7;
  localparam logic [3:0] ADDR_PIN_OUT = 4'h8;
  localparam logic [3:0] ADDR_IDENT = 4'h9;
  localparam logic [3:0] ADDR_TEST = 4'hF;
  localparam logic [3:0] READ_ADDR_RST = 4'h1;
  // Common summary bits
  localparam int BIT_FAIL_MODE = 11;
  localparam int BIT_DEV_SUM = 10;
  localparam int BIT_OVERLOAD = 9;
  localparam int BIT_OPEN_LOAD = 8;
  // Quick status word
  localparam int BIT_PWM_CLOCK_FAIL_FLAG = 5;
  localparam int BIT_RCF = 6;
  localparam int BIT_CPF = 7;
  // Channel status word
  localparam int BIT_OLOFF = 0;
  localparam int BIT_OLON = 1;
  localparam int OC_LSB = 2;
  localparam int BIT_OTW = 5;
  localparam int BIT_OTS = 6;
  // Device status word
  localparam int BIT_LIMP = 0;
  localparam int BIT_SERIAL_FAIL_FLAG = 1;
  localparam int BIT_UVF = 2;
  localparam int BIT_OVF = 3;
  localparam int BIT_TMF = 4;
  // Pin and output word
  localparam int CMP_LSB = 0;
  localparam int DIN_LSB = 5;
  localparam int BIT_TOGGLE = 9;
  // Identification word
  localparam int TYPE_LSB = 0;
  localparam int FAMILY_LSB = 3;
  localparam int REV_LSB = 5;
  localparam int BIT_ID_UV = 10;
  // Reset values and fills
  localparam logic RCF_RST = 1'b1;
  localparam logic [DATA_W-1:0] UNUSED_FILL = 12'h000;
  localparam logic [DATA_W-1:0] WORD_RST = 12'h000;
  typedef enum logic [2:0] {
    OC_NONE = 3'h0,
    OC_HIGH_ONE = 3'h1,
    OC_HIGH_TWO = 3'h2,
    OC_HIGH_THREE = 3'h3,
    OC_LOW = 3'h4,
    OC_ON_DEMAND = 3'h5,
    OC_SEVERE_SHORT = 3'h6,
    OC_UNUSED = 3'h7
  } oc_code_e;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_FINISH = 2'b11
  } frame_state_e;
endpackage

// *** core/sync_bank.sv ***
// Two-flop synchronisers for asynchronous pins
`timescale 1ns/1ns
module sync_bank
  import stat_pkg::*;
#(
  parameter int W = NPIN_SYNC
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_r[i] <= 1'b0;
          hold_r[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= d[i];
          hold_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign q = hold_r;
endmodule

// *** core/word_shifter.sv ***
// Serial frame engine: shifts one status word out per chip-select frame
`timescale 1ns/1ns
module word_shifter
  import stat_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic csb_s,
  input wire logic sclk_s,
  input wire logic si_s,
  output logic so_data,
  output logic so_oe_n,
  frame_if.shifter fr
);
  frame_state_e state_r;
  frame_state_e state_nxt;
  logic csb_d_r;
  logic sclk_d_r;
  logic [WORD_W-1:0] sh_r;
  logic [WORD_W-1:0] rx_r;
  logic [3:0] cnt_r;
  logic any_r;
  logic so_r;
  logic oe_n_r;
  logic done_r;
  logic good_r;

  wire csb_fall = csb_d_r & ~csb_s;
  wire csb_rise = ~csb_d_r & csb_s;
  wire sclk_fall = sclk_d_r & ~sclk_s;
  wire in_shift = (state_r == FR_SHIFT);
  wire bit_step = in_shift & sclk_fall & ~csb_s;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      FR_IDLE: if (csb_fall) state_nxt = FR_SHIFT;
      FR_SHIFT: if (csb_rise) state_nxt = FR_FINISH;
      FR_FINISH: state_nxt = FR_IDLE;
      default: state_nxt = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= FR_IDLE;
      csb_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      csb_d_r <= csb_s;
      sclk_d_r <= sclk_s;
    end
  end

  // Word loads at frame start; SI sampled and SO advanced on SCLK falling
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_r <= 16'h0000;
      rx_r <= 16'h0000;
      cnt_r <= 4'h0;
      any_r <= 1'b0;
    end
    else if (state_r == FR_IDLE && csb_fall)
    begin
      sh_r <= fr.tx_word;
      cnt_r <= 4'h0;
      any_r <= 1'b0;
    end
    else if (bit_step)
    begin
      sh_r <= {sh_r[WORD_W-2:0], 1'b0};
      rx_r <= {rx_r[WORD_W-2:0], si_s};
      cnt_r <= cnt_r + 4'h1;
      any_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      so_r <= 1'b0;
      oe_n_r <= 1'b1;
      done_r <= 1'b0;
      good_r <= 1'b0;
    end
    else
    begin
      done_r <= in_shift & csb_rise;
      good_r <= any_r & (cnt_r == 4'h0);
      if (state_r == FR_IDLE && csb_fall)
        so_r <= fr.tx_word[WORD_W-1];
      else if (bit_step)
        so_r <= sh_r[WORD_W-2];
      if (state_r == FR_IDLE && csb_fall)
        oe_n_r <= 1'b0;
      else if (in_shift && csb_rise)
        oe_n_r <= 1'b1;
    end
  end

  assign so_data = so_r;
  assign so_oe_n = oe_n_r;
  // Start marks the load cycle so the snapshot matches the shipped word
  assign fr.start = (state_r == FR_IDLE) & csb_fall;
  assign fr.done = done_r;
  assign fr.good = good_r;
  assign fr.rx_word = rx_r;
endmodule

// *** verification/spi_master_model.sv ***
// Serial bus master model that runs one framed transfer at a time
`timescale 1ns/1ns
module spi_master_model (
  input wire logic clk,
  output logic csb,
  output logic sclk,
  output logic si,
  input wire logic so_data,
  input wire logic so_oe_n
);
  initial
  begin
    csb = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  task automatic wait_neg(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Half period of 400 ns is four system cycles; SO taken just before each fall
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    wait_neg(1);
    csb = 1'b0;
    wait_neg(4);
    for (int i = 0; i < nbits; i++)
    begin
      si = w[15 - (i % 16)];
      sclk = 1'b1;
      wait_neg(4);
      if (i < 16)
        r[15 - i] = so_oe_n ? 1'bx : so_data;
      sclk = 1'b0;
      wait_neg(4);
    end
    csb = 1'b1;
    // Released data line must not keep the last bit
    si = ~si;
    wait_neg(6);
  endtask
endmodule

// *** verification/spi_status_readback_map_tb.sv ***
// Testbench for the serial status readback word map
`timescale 1ns/1ns
module spi_status_readback_map_tb;
  import stat_pkg::*;
  logic clk_sys, nrst, csb, sclk, si, so_data, so_oe_n;
  logic limp_pin, fail_mode, undervolt, overvolt, cp_fault, clock_fail, test_mode;
  logic [3:0] direct_in, input_on;
  logic [4:0] out_cmp, otw, ots, olon, oloff;
  logic [14:0] oc_code;
  logic [15:0] rd;
  logic [2:0] kc;
  int ch;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  spi_status_readback_map #(.DEVICE_TYPE(3'h5), .DEVICE_FAMILY(2'h2), .DESIGN_REV(3'h3)) i_dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .CSB(csb), .SCLK(sclk), .SI(si),
    .SO_DATA(so_data), .SO_OE_N(so_oe_n), .LIMP_PIN(limp_pin), .DIRECT_IN(direct_in),
    .OUT_CMP(out_cmp), .FAIL_MODE(fail_mode), .INPUT_ON(input_on), .CH_OC_CODE(oc_code),
    .CH_OTW(otw), .CH_OTS(ots), .CH_OLON(olon), .CH_OLOFF(oloff), .UNDERVOLT(undervolt),
    .OVERVOLT(overvolt), .CP_FAULT(cp_fault), .CLOCK_FAIL(clock_fail), .TEST_MODE(test_mode)
  );

  spi_master_model i_master (
    .clk(clk_sys), .csb(csb), .sclk(sclk), .si(si), .so_data(so_data), .so_oe_n(so_oe_n)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [15:0] w, input logic [15:0] exp);
    logic [15:0] r;
    i_master.xfer(w, 16, r);
    check(r, exp);
  endtask

  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask

  initial
  begin
    nrst = 1'b0;
    {limp_pin, fail_mode, undervolt, overvolt, cp_fault, clock_fail, test_mode} = 7'h00;
    {direct_in, input_on, out_cmp, otw, ots, olon, oloff, oc_code} = 48'h0;
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    settle();
    frame(16'h1000, 16'h1440);
    frame(16'h1000, 16'h1000);
    // Every overcurrent code, spread over all channels
    for (int k = 1; k <= 6; k++)
    begin
      ch = (k - 1) % 5;
      kc = 3'(k);
      i_master.xfer({ADDR_CH1 + 4'(ch), 12'h000}, 16, rd);
      fail_mode = kc[0];
      oc_code = 15'(kc) << (3 * ch);
      otw[ch] = kc[0];
      oloff[ch] = kc[1];
      olon[ch] = kc[2];
      ots[ch] = (k == 6);
      @(negedge clk_sys);
      {otw, ots, olon, oloff, oc_code} = 35'h0;
      settle();
      frame(16'h1000, {ADDR_CH1 + 4'(ch), kc[0], 2'b01, kc[1] | kc[2], 1'b0,
        k == 6, kc[0], kc, kc[2], kc[1]});
    end
    fail_mode = 1'b0;
    i_master.xfer({ADDR_DEVICE, 12'h000}, 16, rd);
    {undervolt, overvolt, test_mode, limp_pin} = 4'hF;
    @(negedge clk_sys);
    {undervolt, overvolt, test_mode} = 3'h0;
    settle();
    frame({ADDR_DEVICE, 12'h000}, 16'h741D);
    // Short frame is refused and leaves the selection alone
    i_master.xfer(16'h9000, 8, rd);
    frame({ADDR_QUICK, 12'h000}, 16'h7003);
    frame({ADDR_QUICK, 12'h000}, 16'h1000);
    {cp_fault, clock_fail, olon[2]} = 3'h7;
    @(negedge clk_sys);
    {cp_fault, clock_fail, olon[2]} = 3'h0;
    settle();
    frame({ADDR_QUICK, 12'h000}, 16'h15A4);
    frame({ADDR_PIN_OUT, 12'h000}, 16'h1104);
    {out_cmp, direct_in, input_on, fail_mode, undervolt, limp_pin} = 16'hAD26;
    @(negedge clk_sys);
    undervolt = 1'b0;
    settle();
    frame({ADDR_IDENT, 12'h000}, 16'h8B55);
    frame(16'hA000, 16'h9C75);
    i_master.xfer({ADDR_TEST, 12'h000}, 16, rd);
    check({rd[15:12], 12'h000}, 16'hA000);
    i_master.xfer({ADDR_UNUSED0, 12'h000}, 16, rd);
    check({rd[15:12], 12'h000}, 16'hF000);
    frame({ADDR_QUICK, 12'h000}, 16'h0000);
    tally_and_finish();
  end
endmodule
